// ==== rtl/bridge_cfg_consts.svh ====
// Offsets, field positions, reset values and fixed codes of the bridge
// configuration slice. Assumes a 12-bit byte address on the register bus.
`ifndef BRIDGE_CFG_CONSTS_SVH
`define BRIDGE_CFG_CONSTS_SVH

`define ADDR_W 12
`define OFF_CLASS 12'h008
`define OFF_SUB_DEC 12'h098
`define OFF_SLOT_ID 12'h0a0
`define OFF_SCLK_CTL 12'h0a4
`define OFF_PCIE_CAP 12'h0b0
`define OFF_EXT_BASE 12'h100

`define SUB_BRIDGE_BIT 0
`define PCI_SUB_BIT 1
`define CAP_ID_LSB 0
`define NEXT_PTR_LSB 8
`define SLOT_NUM_LSB 16
`define FIRST_CH_BIT 21
`define CHASSIS_LSB 24
`define CLK0_LSB 0
`define CLK1_LSB 2
`define CLASS_LSB 8

`define CLASS_SUBTRACTIVE 24'h06_0401
`define CLASS_NORMAL 24'h06_0400
`define SLOT_CAP_ID 8'h04
`define SLOT_NEXT_PTR 8'hb0
`define CLK_STOP_CODE 2'h3
`define CLK_CODE_RST 2'h0
`define SLOT_NUM_RST 5'h00
`define CHASSIS_RST 8'h00
`define WORD_ZERO 32'h0000_0000
`define REV_ID_DEFAULT 8'h5a

`endif

// ==== rtl/bridge_cfg_pkg.sv ====
// Types shared by the bridge configuration slice.
// Assumes the constants header supplies all numeric values.
package bridge_cfg_pkg;
	typedef logic [31:0] word_t;
	typedef logic [23:0] class_code_t;
	typedef logic [1:0] clk_code_t;
	typedef logic [4:0] slot_num_t;
	typedef logic [7:0] byte_t;
endpackage

// ==== rtl/bridge_decode_slot_clock_cfg.sv ====
// Configuration registers for subtractive decode, slot identification and
// secondary clock output enables of a PCIe-to-PCI bridge, on an APB slave.
// Assumes decode-hit inputs and serial-ROM load strobes come from logic on clk_i.
`timescale 1ns/1ns
`include "bridge_cfg_consts.svh"

module bridge_decode_slot_clock_cfg
	import bridge_cfg_pkg::*;
#(
	parameter class_code_t NORMAL_CLASS = `CLASS_NORMAL,
	parameter byte_t REVISION_ID = `REV_ID_DEFAULT // Arbitrary value
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [`ADDR_W-1:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	input wire logic rom_load_i,
	input wire logic rom_slot_id_en_i,
	input wire logic window_hit_i,
	input wire logic pci_unclaimed_i,
	output logic forward_o,
	output logic pci_sub_claim_o,
	output logic [23:0] class_code_o,
	output logic secondary_clock_out_zero_o,
	output logic secondary_clock_out_slot_one_o
);

	// Register state
	logic sub_bridge_r;
	logic pci_sub_r;
	logic slot_present_r;
	slot_num_t slot_num_r;
	logic first_chassis_r;
	byte_t chassis_r;
	clk_code_t clk0_code_r;
	clk_code_t clk1_code_r;
	word_t pcie_cap_r;
	word_t prdata_r;
	logic pslverr_r;
	logic forward_r;
	logic claim_r;
	class_code_t class_r;
	logic clk_div_r;
	logic clk0_out_r;
	logic clk1_out_r;
	word_t rd_nxt;
	logic err_nxt;
	logic wr_en;

	// True for the PCIe capability word and the extended space
	function automatic logic is_cap_space(input logic [`ADDR_W-1:0] a);
		is_cap_space = (a == `OFF_PCIE_CAP) || (a >= `OFF_EXT_BASE);
	endfunction

	// Code 11 is the only code that stops a clock output
	function automatic logic clk_stopped(input clk_code_t c);
		clk_stopped = (c == `CLK_STOP_CODE);
	endfunction

	// Zero wait states keep the master simple; writes land in the access phase
	assign pready_o = 1'b1;
	assign wr_en = psel_i && penable_i && pwrite_i;
	assign prdata_o = prdata_r;
	assign pslverr_o = pslverr_r;
	assign forward_o = forward_r;
	assign pci_sub_claim_o = claim_r;
	assign class_code_o = class_r;
	assign secondary_clock_out_zero_o = clk0_out_r;
	assign secondary_clock_out_slot_one_o = clk1_out_r;

	// Read mux and unmapped-address decode, evaluated in the setup phase
	always_comb begin
		rd_nxt = `WORD_ZERO;
		err_nxt = 1'b0;
		if (paddr_i == `OFF_CLASS) begin
			rd_nxt[31:`CLASS_LSB] = class_r;
			rd_nxt[`CLASS_LSB-1:0] = REVISION_ID;
		end else if (paddr_i == `OFF_SUB_DEC) begin
			rd_nxt[`SUB_BRIDGE_BIT] = sub_bridge_r;
			rd_nxt[`PCI_SUB_BIT] = pci_sub_r;
		end else if (paddr_i == `OFF_SLOT_ID) begin
			// Absent capability reads as all zero
			if (slot_present_r) begin
				rd_nxt[`CAP_ID_LSB+:8] = `SLOT_CAP_ID;
				rd_nxt[`NEXT_PTR_LSB+:8] = `SLOT_NEXT_PTR;
				rd_nxt[`SLOT_NUM_LSB+:5] = slot_num_r;
				rd_nxt[`FIRST_CH_BIT] = first_chassis_r;
				rd_nxt[`CHASSIS_LSB+:8] = chassis_r;
			end
		end else if (paddr_i == `OFF_SCLK_CTL) begin
			rd_nxt[`CLK0_LSB+:2] = clk0_code_r;
			rd_nxt[`CLK1_LSB+:2] = clk1_code_r;
		end else if (is_cap_space(paddr_i)) begin
			// Reserved in subtractive mode; the extended space has no storage here
			if (!sub_bridge_r && paddr_i == `OFF_PCIE_CAP) begin
				rd_nxt = pcie_cap_r;
			end else if (!sub_bridge_r) begin
				err_nxt = 1'b1;
			end // else zero
		end else begin
			err_nxt = 1'b1;
		end
	end

	// Read data and error captured at setup, stable through the access phase
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			prdata_r <= `WORD_ZERO;
			pslverr_r <= 1'b0;
		end else if (psel_i && !penable_i) begin
			prdata_r <= pwrite_i ? `WORD_ZERO : rd_nxt;
			pslverr_r <= err_nxt;
		end
	end

	// Decode controls at 98h
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			sub_bridge_r <= 1'b0;
			pci_sub_r <= 1'b0;
		end else if (wr_en && paddr_i == `OFF_SUB_DEC) begin
			sub_bridge_r <= pwdata_i[`SUB_BRIDGE_BIT];
			pci_sub_r <= pwdata_i[`PCI_SUB_BIT];
		end
	end

	// Slot identification presence is only granted by the serial ROM load
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			slot_present_r <= 1'b0;
		end else if (rom_load_i) begin
			slot_present_r <= rom_slot_id_en_i;
		end
	end

	// Writable slot fields; ID and pointer bytes have no storage at all
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			slot_num_r <= `SLOT_NUM_RST;
			first_chassis_r <= 1'b0;
			chassis_r <= `CHASSIS_RST;
		end else if (wr_en && paddr_i == `OFF_SLOT_ID && slot_present_r) begin
			slot_num_r <= pwdata_i[`SLOT_NUM_LSB+:5];
			first_chassis_r <= pwdata_i[`FIRST_CH_BIT];
			chassis_r <= pwdata_i[`CHASSIS_LSB+:8];
		end
	end

	// Secondary clock enable codes
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			clk0_code_r <= `CLK_CODE_RST;
			clk1_code_r <= `CLK_CODE_RST;
		end else if (wr_en && paddr_i == `OFF_SCLK_CTL) begin
			clk0_code_r <= pwdata_i[`CLK0_LSB+:2];
			clk1_code_r <= pwdata_i[`CLK1_LSB+:2];
		end
	end

	// PCIe capability word: live normally, data discarded in subtractive mode
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			pcie_cap_r <= `WORD_ZERO;
		end else if (wr_en && paddr_i == `OFF_PCIE_CAP && !sub_bridge_r) begin
			pcie_cap_r <= pwdata_i;
		end
	end

	// Class code and forwarding decisions, one cycle behind their causes
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			class_r <= `CLASS_NORMAL;
			forward_r <= 1'b0;
			claim_r <= 1'b0;
		end else begin
			class_r <= sub_bridge_r ? `CLASS_SUBTRACTIVE : NORMAL_CLASS;
			forward_r <= sub_bridge_r || window_hit_i;
			claim_r <= pci_sub_r && pci_unclaimed_i;
		end
	end

	// Clock outputs at half clk_i; a stopped output is held low, not tristated.
	// Stopping output zero starves the secondary logic unless fed externally.
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			clk_div_r <= 1'b0;
			clk0_out_r <= 1'b0;
			clk1_out_r <= 1'b0;
		end else begin
			clk_div_r <= !clk_div_r;
			clk0_out_r <= clk_stopped(clk0_code_r) ? 1'b0 : clk_div_r;
			clk1_out_r <= clk_stopped(clk1_code_r) ? 1'b0 : clk_div_r;
		end
	end

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	// Helper: the register access phase
	logic acc;
	assign acc = psel_i && penable_i;

	a_class_sub: assert property (
		$past(sub_bridge_r) |-> class_code_o == `CLASS_SUBTRACTIVE
	) else $error("class code not subtractive");

	a_class_norm: assert property (
		$past(!sub_bridge_r) && $past(!rst_i) |-> class_code_o == NORMAL_CLASS
	) else $error("class code not normal");

	a_forward_all: assert property (
		sub_bridge_r && $stable(sub_bridge_r) |=> forward_o
	) else $error("cycle not forwarded");

	a_cap_wr_drop: assert property (
		acc && pwrite_i && paddr_i == `OFF_PCIE_CAP && sub_bridge_r |=> $stable(pcie_cap_r)
	) else $error("capability write not discarded");

	a_cap_rd_zero: assert property (
		acc && !pwrite_i && is_cap_space(paddr_i) && sub_bridge_r && $stable(sub_bridge_r)
		|-> prdata_o == `WORD_ZERO && !pslverr_o
	) else $error("capability read not zero");

	a_pci_claim: assert property (
		##1 pci_sub_claim_o == ($past(pci_sub_r) && $past(pci_unclaimed_i))
	) else $error("claim mismatch");

	a_cap_id: assert property (
		acc && !pwrite_i && paddr_i == `OFF_SLOT_ID && slot_present_r && $stable(slot_present_r)
		|-> prdata_o[`CAP_ID_LSB+:8] == `SLOT_CAP_ID && prdata_o[`NEXT_PTR_LSB+:8] == `SLOT_NEXT_PTR
	) else $error("slot id bytes wrong");

	a_slot_absent: assert property (
		acc && !pwrite_i && paddr_i == `OFF_SLOT_ID && !slot_present_r && $stable(slot_present_r)
		|-> prdata_o == `WORD_ZERO
	) else $error("absent slot capability visible");

	a_clk0_low: assert property (
		clk_stopped(clk0_code_r) [*2] |-> !secondary_clock_out_zero_o
	) else $error("clock zero not held low");

	a_clk1_low: assert property (
		clk_stopped(clk1_code_r) [*2] |-> !secondary_clock_out_slot_one_o
	) else $error("slot one clock not held low");

	a_clk1_run: assert property (
		!clk_stopped(clk1_code_r) [*3] |-> secondary_clock_out_slot_one_o != $past(secondary_clock_out_slot_one_o)
	) else $error("slot one clock not toggling");

	a_clk0_run: assert property (
		!clk_stopped(clk0_code_r) [*3] |-> secondary_clock_out_zero_o != $past(secondary_clock_out_zero_o)
	) else $error("clock zero not toggling");

	a_clk0_stop_wr: assert property (
		acc && pwrite_i && paddr_i == `OFF_SCLK_CTL && clk_stopped(pwdata_i[`CLK0_LSB+:2])
		|=> ##1 !secondary_clock_out_zero_o
	) else $error("clock zero not stopped after write");

	a_clk1_stop_wr: assert property (
		acc && pwrite_i && paddr_i == `OFF_SCLK_CTL && clk_stopped(pwdata_i[`CLK1_LSB+:2])
		|=> ##1 !secondary_clock_out_slot_one_o
	) else $error("slot one clock not stopped after write");

	// Register bus: write effects land at the access edge, reads are taken at setup
	a_sub_wr: assert property (
		acc && pwrite_i && paddr_i == `OFF_SUB_DEC
		|=> sub_bridge_r == $past(pwdata_i[`SUB_BRIDGE_BIT]) && pci_sub_r == $past(pwdata_i[`PCI_SUB_BIT])
	) else $error("decode control write lost");

	a_dec_rsv: assert property (
		acc && !pwrite_i && paddr_i == `OFF_SUB_DEC |-> (prdata_o >> (`PCI_SUB_BIT + 1)) == `WORD_ZERO
	) else $error("decode control reserved bits set");

	a_clk_code_wr: assert property (
		acc && pwrite_i && paddr_i == `OFF_SCLK_CTL
		|=> clk0_code_r == $past(pwdata_i[`CLK0_LSB+:2]) && clk1_code_r == $past(pwdata_i[`CLK1_LSB+:2])
	) else $error("clock code write lost");

	a_sclk_rsv: assert property (
		acc && !pwrite_i && paddr_i == `OFF_SCLK_CTL |-> (prdata_o >> (`CLK1_LSB + 2)) == `WORD_ZERO
	) else $error("clock control reserved bits set");

	a_class_rd: assert property (
		acc && !pwrite_i && paddr_i == `OFF_CLASS && $stable(class_code_o)
		|-> (prdata_o >> `CLASS_LSB) == 32'(class_code_o)
	) else $error("class word readback wrong");

	a_cap_wr_keep: assert property (
		acc && pwrite_i && paddr_i == `OFF_PCIE_CAP && !sub_bridge_r |=> pcie_cap_r == $past(pwdata_i)
	) else $error("capability write lost");

	a_cap_rd_norm: assert property (
		acc && !pwrite_i && paddr_i == `OFF_PCIE_CAP && !sub_bridge_r && $stable(sub_bridge_r) && $stable(pcie_cap_r)
		|-> prdata_o == pcie_cap_r && !pslverr_o
	) else $error("capability read not live");

	a_ext_err: assert property (
		acc && !pwrite_i && paddr_i >= `OFF_EXT_BASE && !sub_bridge_r && $stable(sub_bridge_r)
		|-> pslverr_o
	) else $error("extended space error missing");

	// Slot identification presence follows the serial load alone
	a_slot_load: assert property (
		rom_load_i |=> slot_present_r == $past(rom_slot_id_en_i)
	) else $error("slot presence not loaded");

	a_slot_hold: assert property (
		!rom_load_i |=> $stable(slot_present_r)
	) else $error("slot presence changed without load");

	a_slot_deaf: assert property (
		acc && pwrite_i && paddr_i == `OFF_SLOT_ID && !slot_present_r
		|=> $stable(slot_num_r) && $stable(chassis_r) && $stable(first_chassis_r)
	) else $error("absent slot capability took a write");

	// Decode outputs follow their causes one cycle later
	a_fwd_window: assert property (
		!sub_bridge_r |=> forward_o == $past(window_hit_i)
	) else $error("positive decode mismatch");

	a_claim_on: assert property (
		pci_sub_r && pci_unclaimed_i |=> pci_sub_claim_o
	) else $error("unclaimed cycle not claimed");

endmodule

// ==== tb/bridge_decode_slot_clock_cfg_tb_top.sv ====
// Self-checking bench for the bridge configuration slice, driven over APB.
// Assumes zero wait states and decode outputs registered one cycle late.
`timescale 1ns/1ns
`include "bridge_cfg_consts.svh"

module bridge_decode_slot_clock_cfg_tb_top;
	import bridge_cfg_pkg::*;
	logic clk_i, rst_i, psel, pen, pwr, rom_ld, rom_en, hit, unc, er, p0, p1;
	logic pready_o, pslverr_o, fwd, claim, ck0, ck1;
	logic [11:0] paddr;
	word_t pwdata, prdata_o, rd, v;
	class_code_t cls;
	int error_cnt, n_checks;

	bridge_decode_slot_clock_cfg i_bridge_decode_slot_clock_cfg (.clk_i(clk_i), .rst_i(rst_i), .psel_i(psel),
		.penable_i(pen), .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata_o),
		.pready_o(pready_o), .pslverr_o(pslverr_o), .rom_load_i(rom_ld), .rom_slot_id_en_i(rom_en),
		.window_hit_i(hit), .pci_unclaimed_i(unc), .forward_o(fwd), .pci_sub_claim_o(claim),
		.class_code_o(cls), .secondary_clock_out_zero_o(ck0), .secondary_clock_out_slot_one_o(ck1));

	// Core clock, 4 ns period
	initial begin
		clk_i = 1'b0;
		forever #2 clk_i = ~clk_i;
	end

	// Verdict and end of run
	task end_of_test();
		$display("checks %0d errors %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
		n_checks++;
		if (s !== e) begin
			error_cnt++;
			$display("[FAIL] %s expected %h seen %h", nm, e, s);
		end
	endtask

	// One APB transfer; the wait for pready is bounded so a hang ends the run
	task apb(input logic w, input logic [11:0] a, input word_t d);
		int n;
		@(posedge clk_i);
		psel <= 1'b1;
		pen <= 1'b0;
		pwr <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_i);
		pen <= 1'b1;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (pready_o !== 1'b1 && n < 16);
		if (pready_o !== 1'b1) begin
			chk("pready", 32'h1, {31'h0, pready_o});
			end_of_test();
		end
		rd = prdata_o;
		er = pslverr_o;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask

	task rchk(input string nm, input logic [11:0] a, input word_t e, input logic ee);
		apb(1'b0, a, 32'h0);
		chk(nm, e, rd);
		chk({nm, "_err"}, {31'h0, ee}, {31'h0, er});
	endtask

	// Let registered outputs land before looking at them
	task settle();
		repeat (2) @(posedge clk_i);
		#1;
	endtask

	// Random decode inputs against the expected forwarding and claiming
	task dec_chk(input logic sub, input logic psub);
		repeat (6) begin
			@(posedge clk_i);
			hit <= 1'($urandom);
			unc <= 1'($urandom);
			settle();
			chk("forward", {31'h0, sub | hit}, {31'h0, fwd});
			chk("claim", {31'h0, psub & unc}, {31'h0, claim});
		end
		chk("class", {8'h0, sub ? `CLASS_SUBTRACTIVE : `CLASS_NORMAL}, {8'h0, cls});
	endtask

	// Expected slot word once present: reserved bits 23:22 read zero
	function automatic word_t slot_exp(input word_t w);
		slot_exp = {w[31:24], 2'h0, w[21:16], `SLOT_NEXT_PTR, `SLOT_CAP_ID};
	endfunction

	// Next level of a clock output: a running one flips, a stopped one stays low
	function automatic logic clk_exp(input logic [1:0] c, input logic prev);
		clk_exp = (c != `CLK_STOP_CODE) && !prev;
	endfunction

	// One-cycle serial load strobe carrying the presence bit
	task rom_pulse(input logic en);
		@(posedge clk_i);
		rom_ld <= 1'b1;
		rom_en <= en;
		@(posedge clk_i);
		rom_ld <= 1'b0;
	endtask

	// A running output must flip every cycle, a stopped one stays low
	task clk_chk(input logic [1:0] c0, input logic [1:0] c1);
		apb(1'b1, `OFF_SCLK_CTL, {28'h0, c1, c0});
		rchk("sclk_rw", `OFF_SCLK_CTL, {28'h0, c1, c0}, 1'b0);
		settle();
		p0 = ck0;
		p1 = ck1;
		repeat (3) begin
			@(posedge clk_i);
			#1;
			chk("clk0", {31'h0, clk_exp(c0, p0)}, {31'h0, ck0});
			chk("clk1", {31'h0, clk_exp(c1, p1)}, {31'h0, ck1});
			p0 = ck0;
			p1 = ck1;
		end
	endtask

	initial begin
		error_cnt = 0;
		n_checks = 0;
		rst_i = 1'b1;
		{psel, pen, pwr, rom_ld, rom_en, hit, unc} = 7'h0;
		paddr = 12'h0;
		pwdata = 32'h0;
		void'($urandom(32'h1c3a));
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		// Reset values and an unmapped hole
		rchk("sub_dec", `OFF_SUB_DEC, 32'h0, 1'b0);
		rchk("class_reg", `OFF_CLASS, {`CLASS_NORMAL, `REV_ID_DEFAULT}, 1'b0);
		rchk("unmapped", 12'h09c, 32'h0, 1'b1);
		// Slot capability stays hidden, and deaf, until the serial load
		apb(1'b1, `OFF_SLOT_ID, 32'hffff_ffff);
		rchk("slot_absent", `OFF_SLOT_ID, 32'h0, 1'b0);
		rom_pulse(1'b1);
		rchk("slot_rst", `OFF_SLOT_ID, {16'h0, `SLOT_NEXT_PTR, `SLOT_CAP_ID}, 1'b0);
		v = $urandom;
		apb(1'b1, `OFF_SLOT_ID, v);
		rchk("slot_rw", `OFF_SLOT_ID, slot_exp(v), 1'b0);
		// Positive decode with PCI side claiming
		apb(1'b1, `OFF_SUB_DEC, 32'h0000_0002);
		dec_chk(1'b0, 1'b1);
		apb(1'b1, `OFF_PCIE_CAP, v);
		rchk("cap_norm", `OFF_PCIE_CAP, v, 1'b0);
		rchk("ext_norm", `OFF_EXT_BASE, 32'h0, 1'b1);
		// Subtractive mode hides capability space and forwards everything
		apb(1'b1, `OFF_SUB_DEC, 32'hffff_ffff);
		rchk("sub_rw", `OFF_SUB_DEC, 32'h3, 1'b0);
		dec_chk(1'b1, 1'b1);
		apb(1'b1, `OFF_PCIE_CAP, ~v);
		rchk("cap_sub", `OFF_PCIE_CAP, 32'h0, 1'b0);
		rchk("ext_sub", `OFF_EXT_BASE + 12'h010, 32'h0, 1'b0);
		apb(1'b1, `OFF_SUB_DEC, 32'h0);
		rchk("cap_back", `OFF_PCIE_CAP, v, 1'b0);
		dec_chk(1'b0, 1'b0);
		// Every enable code on both clock outputs, then a random pair
		for (int c = 0; c < 4; c++) clk_chk(2'(c), 2'(3 - c));
		clk_chk(2'($urandom), 2'($urandom));
		// Software leaves output zero running once the stop test is over
		apb(1'b1, `OFF_SCLK_CTL, 32'h0000_0000);
		rchk("sclk_keep", `OFF_SCLK_CTL, 32'h0, 1'b0);
		// A later serial load with presence clear withdraws the capability
		rom_pulse(1'b0);
		rchk("slot_off", `OFF_SLOT_ID, 32'h0, 1'b0);
		// Mid-run reset returns every field to its reset value
		rom_pulse(1'b1);
		apb(1'b1, `OFF_SUB_DEC, 32'h0000_0003);
		apb(1'b1, `OFF_SCLK_CTL, 32'h0000_000c);
		@(posedge clk_i);
		rst_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		rchk("sub_dec_rst", `OFF_SUB_DEC, 32'h0, 1'b0);
		rchk("sclk_rst", `OFF_SCLK_CTL, 32'h0, 1'b0);
		rchk("slot_rst_off", `OFF_SLOT_ID, 32'h0, 1'b0);
		dec_chk(1'b0, 1'b0);
		end_of_test();
	end
endmodule
